// *** bench/adc_ready_monitor.sv ***
/* bound checker of the serial ready port of the converter interface.
   assumes one core_clk domain and rst active high. */
`timescale 1ns/1ps
module adc_ready_monitor #(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic                        core_clk,
    input wire logic                        rst,
    input wire spi_ready_pkg::serial_in_t   pins,
    input wire logic                        ready_on_output_select,
    input wire logic                        conv_done,
    input wire spi_ready_pkg::result_word_t conv_data,
    input wire logic                        conv_ready,
    input wire logic                        result_ready_n,
    input wire logic                        shared_out_ready_pin_o,
    input wire logic                        shared_out_ready_pin_oe,
    input wire logic                        continuous_read_mode,
    input wire logic                        conv_restart
);
    import spi_ready_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_float_desel: assert property (pins.cs_n [*5] |-> !shared_out_ready_pin_oe)
        else $error("pin driven while deselected");
    a_drive_sel: assert property ((!pins.cs_n) [*5] |-> shared_out_ready_pin_oe)
        else $error("pin not driven while selected");
    a_ready_falls: assert property (conv_done && conv_ready && result_ready_n
        |-> ##2 !result_ready_n) else $error("ready did not fall");
    a_ready_clear: assert property ($fell(pins.sclk) && !result_ready_n
        |-> ##[1:5] result_ready_n) else $error("sclk did not clear ready");
    a_pulse_high: assert property (conv_done && conv_ready && !result_ready_n
        |-> ##[1:4] result_ready_n [*4] ##[1:8] !result_ready_n) else $error("no ready pulse");
    a_reset_values: assert property (disable iff (1'b0) rst && $past(rst) |-> conv_restart
        && continuous_read_mode && result_ready_n && !shared_out_ready_pin_oe && !conv_ready)
        else $error("wrong values in reset");
    a_restart_pulse: assert property ($fell(rst) |-> ##1 (conv_ready && !conv_restart))
        else $error("restart not released");
    a_combined_fall: assert property (ready_on_output_select && continuous_read_mode
        && !pins.cs_n && conv_done && conv_ready |-> ##[1:12] !shared_out_ready_pin_o)
        else $error("shared pin did not fall");
    c_deselected: cover property (conv_done && pins.cs_n);
    c_pulse: cover property (conv_done && !result_ready_n);
    c_combined: cover property (ready_on_output_select && $fell(shared_out_ready_pin_o));
endmodule // adc_ready_monitor

bind adc_spi_slave_ready_iface adc_ready_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) u_ready_mon (
    .core_clk, .rst, .pins, .ready_on_output_select, .conv_done, .conv_data, .conv_ready,
    .result_ready_n, .shared_out_ready_pin_o, .shared_out_ready_pin_oe, .continuous_read_mode,
    .conv_restart);

// *** bench/adc_spi_slave_ready_iface_tb_top.sv ***
/* top bench: converter side stimulus, host model, port checks.
   assumes the monitor binds itself and the host model sits beside. */
`timescale 1ns/1ps
`include "spi_ready_map.svh"
module adc_spi_slave_ready_iface_tb_top;
    import spi_ready_pkg::*;
    logic         core_clk, rst, sel_mode, conv_done, conv_ready, result_ready_n;
    logic         pin_o, pin_oe, cont, restart, miso;
    serial_in_t   pins;
    result_word_t conv_data;
    int           n_errors = 0, checks = 0, seed = 18;
    logic [7:0]   rx;
    logic [15:0]  d, w;

    adc_spi_slave_ready_iface #(.FIFO_DEPTH(8)) u_dut (.core_clk(core_clk), .rst(rst),
        .pins(pins), .ready_on_output_select(sel_mode), .conv_done(conv_done),
        .conv_data(conv_data), .conv_ready(conv_ready), .result_ready_n(result_ready_n),
        .shared_out_ready_pin_o(pin_o), .shared_out_ready_pin_oe(pin_oe),
        .continuous_read_mode(cont), .conv_restart(restart));
    spi_host_model u_host (.core_clk(core_clk), .pin_o(pin_o), .pin_oe(pin_oe), .pins(pins),
        .miso(miso));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // active-low ready level while a result is pending
    function automatic logic ready_level(input logic pending);
        return !pending;
    endfunction
    task automatic check_bit(input logic got, input logic exp, input string what);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t %s: got %b exp %b", $time, what, got, exp);
        end
    endtask
    task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t %s: got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic do_reset();
        @(negedge core_clk);
        rst = 1'b1;
        repeat (12) @(negedge core_clk);
        rst = 1'b0;
        repeat (4) @(negedge core_clk);
        check_bit(cont, 1'b1, "continuous after reset");
        check_bit(result_ready_n, ready_level(1'b0), "ready idle after reset");
    endtask
    // one result from the converter, then the host stays quiet
    task automatic convert(input logic [15:0] v);
        @(negedge core_clk);
        conv_done = 1'b1;
        conv_data = v;
        @(negedge core_clk);
        conv_done = 1'b0;
        repeat (10) @(negedge core_clk);
    endtask
    task automatic read_word(input logic [7:0] cmd2, output logic [15:0] v);
        logic [7:0] hi;
        u_host.xfer(`CMD_NOP, 8, hi);
        u_host.xfer(cmd2, 8, v[7:0]);
        v[15:8] = hi;
    endtask

    initial begin
        #200000;
        n_errors++;
        print_verdict();
    end
    initial begin
        rst = 1'b1;
        sel_mode = 1'b0;
        conv_done = 1'b0;
        conv_data = '0;
        repeat (12) @(negedge core_clk);
        rst = 1'b0;
        repeat (4) @(negedge core_clk);
        convert(16'($random(seed)));
        check_bit(result_ready_n, ready_level(1'b1), "ready while deselected");
        u_host.xfer(8'($random(seed)), 8, rx);
        check_bit(pin_oe, 1'b0, "pin floats");
        check_bit(result_ready_n, ready_level(1'b0), "sclk clears ready");
        convert(16'($random(seed)));
        convert(16'($random(seed)));
        check_bit(result_ready_n, ready_level(1'b1), "ready after pulse");
        $display("test deselected done");
        do_reset();
        sel_mode = 1'b1;
        u_host.select(1'b1);
        d = 16'($random(seed));
        convert(d);
        check_bit(pin_o, ready_level(1'b1), "shared pin marks result");
        read_word(`CMD_NOP, w);
        check_word(w, d, "combined readout");
        check_bit(result_ready_n, ready_level(1'b0), "ready raised by sclk");
        u_host.xfer(`CMD_NOP, 8, rx);
        check_bit(pin_o, ready_level(1'b0), "pin high after readout");
        $display("test combined done");
        sel_mode = 1'b0;
        for (int i = 0; i < 3; i++) begin
            d = 16'($random(seed));
            convert(d);
            read_word((i == 2) ? `CMD_STOP_CONT : `CMD_NOP, w);
            check_word(w, d, "data only readout");
        end
        check_bit(cont, 1'b0, "stop taken while shifting");
        u_host.xfer(`CMD_NOP, 8, rx);
        sel_mode = 1'b1;
        d = 16'($random(seed));
        convert(d);
        check_bit(pin_o, 1'b1, "no ready mark after stop");
        u_host.xfer(`CMD_READ_ONCE, 8, rx);
        read_word(`CMD_NOP, w);
        check_word(w, d, "read once readout");
        sel_mode = 1'b0;
        $display("test data only done");
        u_host.select(1'b0);
        do_reset();
        u_host.select(1'b1);
        u_host.xfer(8'h00, 3, rx);
        repeat (64) convert(16'($random(seed)));
        check_bit(conv_ready, 1'b1, "converter never held off");
        u_host.xfer(`CMD_STOP_CONT, 8, rx);
        check_bit(cont, 1'b0, "port recovered after idle");
        u_host.select(1'b0);
        $display("test idle timeout done");
        print_verdict();
    end
endmodule // adc_spi_slave_ready_iface_tb_top

// *** bench/spi_host_model.sv ***
/* host master model: drives select, serial clock and data, reads the shared pin.
   assumes an 80 ns link clock, 8 core_clk cycles per half, idle low. */
`timescale 1ns/1ps
module spi_host_model (
    input  wire logic                 core_clk,
    input  wire logic                 pin_o,
    input  wire logic                 pin_oe,
    output spi_ready_pkg::serial_in_t pins,
    output logic                      miso
);
    import spi_ready_pkg::*;
    logic last_r = 1'b0;
    always @(posedge core_clk) if (pin_oe) last_r <= pin_o;
    // a released pin shows the inverse of its last level
    assign miso = pin_oe ? pin_o : ~last_r;
    initial pins = '{sclk: 1'b0, cs_n: 1'b1, din: 1'b1};
    // select is held over the whole exchange
    task automatic select(input logic sel);
        @(negedge core_clk);
        pins.cs_n = !sel;
        repeat (8) @(negedge core_clk);
    endtask
    // n bits msb first: change on rise, sample on fall; n below 8 only as a glitch
    task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            @(negedge core_clk);
            pins.sclk = 1'b1;
            pins.din = tx[i];
            repeat (8) @(negedge core_clk);
            pins.sclk = 1'b0;
            rx = {rx[6:0], miso};
            repeat (7) @(negedge core_clk);
        end
    endtask
endmodule // spi_host_model

// *** logic/adc_spi_slave_ready_iface.sv ***
/*
 * serial slave of a converter: chip-select gating, shifting, command watch,
 * dedicated and shared ready signalling, and the three ways the port resets.
 * assumes sclk, cs_n, din come from pins; conv_done/conv_data from the
 * converter on core_clk; rst is the device reset pin, inverted, made high.
 */
// Contract
// RULE1: host holds select low for whole exchange
// RULE2: select high floats pin, resets port
// RULE3: ready output works regardless of select
// RULE4: conversions continue while deselected
// RULE5: sample falling edge, change rising edge
// RULE6: commands decoded while data shifts out
// RULE7: host sends no-op when only reading
// RULE8: ready falls once result is stored
// RULE9: host waits quietly after ready falls
// RULE10: deselected traffic never blocks result loading
// RULE11: first falling clock raises ready again
// RULE12: unread ready pulses high before next
// RULE13: select clear: pin carries data only
// RULE14: select set: data and ready combined; code combines them only in continuous read mode
// RULE15: select bit touches only shared pin
// RULE16: shared pin falls per new result; code: only with select set and continuous read on
// RULE17: continuous read shifts sixteen clocks out
// RULE18: rising edge after full readout raises pin
// RULE19: host clocks only in whole bytes
// RULE20: reset pin resets everything, restarts conversion
// RULE21: host finishes writes in whole bytes
// RULE22: idle 64 conversions resets serial port
`timescale 1ns/1ps
`include "spi_ready_map.svh"

module adc_spi_slave_ready_iface #(
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic                        core_clk,
    input  wire logic                        rst,
    input  wire spi_ready_pkg::serial_in_t   pins,
    input  wire logic                        ready_on_output_select,
    input  wire logic                        conv_done,
    input  wire spi_ready_pkg::result_word_t conv_data,
    output logic                             conv_ready,
    output logic                             result_ready_n,
    output logic                             shared_out_ready_pin_o,
    output logic                             shared_out_ready_pin_oe,
    output logic                             continuous_read_mode,
    output logic                             conv_restart
);
    import spi_ready_pkg::*;

    if (FIFO_DEPTH < 2) begin : g_depth_check
        $error("fifo depth too small");
    end

    // two-flop synchronisers; stage one feeds only stage two
    logic [2:0] s1_r;
    logic [2:0] s2_r;
    logic [2:0] s3_r;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       cs_act;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s1_r <= 3'h0;
            s2_r <= 3'h0;
            s3_r <= 3'h0;
        end else begin
            s1_r <= {pins.sclk, ~pins.cs_n, pins.din};
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    always_comb begin
        sclk_rise = s2_r[2] && !s3_r[2];
        sclk_fall = !s2_r[2] && s3_r[2];
        cs_act    = s2_r[1];
    end

    // result path: converter keeps filling regardless of select [RULE4]
    logic         f_out_valid;
    logic         f_out_ready;
    logic [15:0]  f_out_data;
    logic         f_in_ready;

    result_fifo #(.WIDTH(`RESULT_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk  (core_clk),
        .rst       (rst),
        .in_valid  (conv_done),
        .in_ready  (f_in_ready),
        .in_data   (conv_data.data),
        .out_valid (f_out_valid),
        .out_ready (f_out_ready),
        .out_data  (f_out_data)
    );

    // serial state
    logic [15:0]  res_buf_r;
    logic [15:0]  res_buf_nxt;
    logic [15:0]  shift_r;
    logic [15:0]  shift_nxt;
    logic [4:0]   out_cnt_r;
    logic [4:0]   out_cnt_nxt;
    logic [7:0]   in_sr_r;
    logic [7:0]   in_sr_nxt;
    logic [2:0]   bit_cnt_r;
    logic [2:0]   bit_cnt_nxt;
    logic         cont_r;
    logic         cont_nxt;
    logic         dout_r;
    logic         dout_nxt;
    logic         oe_r;
    logic         oe_nxt;
    logic         drained_r;
    logic         drained_nxt;
    logic [6:0]   idle_r;
    logic [6:0]   idle_nxt;
    logic         pend_r;
    logic         pend_nxt;
    logic         cready_r;
    logic         restart_r;
    ready_state_t rdy_st_r;
    ready_state_t rdy_st_nxt;
    logic [7:0]   pw_r;
    logic [7:0]   pw_nxt;
    logic         rdy_n_r;
    logic         rdy_n_nxt;
    logic         new_res;
    logic         port_rst;
    logic [7:0]   cmd;
    logic         load_now;

    always_comb begin
        new_res     = f_out_valid;
        f_out_ready = 1'b1;
        port_rst    = !cs_act || idle_r >= 7'(`IDLE_TIMEOUT_CONV);         // [RULE2] [RULE22]
        res_buf_nxt = new_res ? f_out_data : res_buf_r;                   // [RULE8]
        shift_nxt   = shift_r;
        out_cnt_nxt = out_cnt_r;
        in_sr_nxt   = in_sr_r;
        bit_cnt_nxt = bit_cnt_r;
        cont_nxt    = cont_r;
        dout_nxt    = dout_r;
        drained_nxt = drained_r;
        pend_nxt    = pend_r;
        cmd         = {in_sr_r[6:0], s2_r[0]};
        idle_nxt    = (conv_done && idle_r < 7'(`IDLE_TIMEOUT_CONV)) ? idle_r + 7'h01 : idle_r;
        // in continuous mode the shift register loads on new result unless a transfer is in flight [RULE10]
        load_now    = new_res && cont_r && (bit_cnt_r == 3'h0 || !cs_act);
        if (load_now) begin
            shift_nxt   = f_out_data;                                     // [RULE17]
            out_cnt_nxt = 5'(`RESULT_BITS);
            drained_nxt = 1'b0;
            pend_nxt    = 1'b1;
        end
        if (port_rst) begin
            bit_cnt_nxt = 3'h0;                                           // [RULE2]
            in_sr_nxt   = 8'h00;
            idle_nxt    = 7'h00;
            dout_nxt    = 1'b1;
        end else begin
            if (sclk_fall) begin
                idle_nxt    = 7'h00;
                in_sr_nxt   = cmd;                                        // [RULE5]
                bit_cnt_nxt = bit_cnt_r + 3'h1;
                if (bit_cnt_r == 3'(`BYTE_BITS - 1)) begin
                    // command decoded even during readout [RULE6]
                    if ((cmd & `CMD_OP_MASK) == `CMD_CONT_READ) begin
                        cont_nxt = 1'b1;
                    end else if ((cmd & `CMD_OP_MASK) == `CMD_STOP_CONT) begin
                        cont_nxt = 1'b0;
                    end else if ((cmd & `CMD_OP_MASK) == `CMD_READ_ONCE) begin
                        shift_nxt   = res_buf_r;
                        out_cnt_nxt = 5'(`RESULT_BITS);
                        drained_nxt = 1'b0;
                    end
                end
            end
            if (sclk_rise) begin
                // a result loaded in the same cycle keeps its marks
                if (!load_now) begin
                    pend_nxt = 1'b0;
                end
                if (out_cnt_r != 5'h00) begin
                    dout_nxt    = shift_r[15];                            // [RULE5] [RULE13]
                    shift_nxt   = {shift_r[14:0], 1'b0};
                    out_cnt_nxt = out_cnt_r - 5'h01;
                end else begin
                    dout_nxt    = 1'b1;                                   // [RULE18]
                    drained_nxt = !load_now;
                end
            end
        end
        // combined mode: new result shows as a low on the idle pin only while continuous read is on [RULE14] [RULE16]
        oe_nxt = cs_act;                                                  // [RULE2]
        if (ready_on_output_select && cont_r && pend_r && !drained_r &&
            !sclk_rise) begin
            dout_nxt = !(new_res && !dout_r) ? 1'b0 : 1'b1;               // [RULE15]
        end
    end

    // dedicated ready output; indifferent to select and to the mode bit [RULE3] [RULE15]
    always_comb begin
        rdy_st_nxt = rdy_st_r;
        pw_nxt     = pw_r;
        rdy_n_nxt  = rdy_n_r;
        case (rdy_st_r)
            RDY_HIGH: begin
                if (new_res) begin
                    rdy_n_nxt  = 1'b0;                                    // [RULE8]
                    rdy_st_nxt = RDY_LOW;
                end
            end
            RDY_LOW: begin
                // a new result wins over a clearing clock in the same cycle
                if (new_res) begin
                    rdy_n_nxt  = 1'b1;                                    // [RULE12]
                    pw_nxt     = 8'(`PULSE_HIGH_CYCLES - 1);
                    rdy_st_nxt = RDY_PULSE;
                end else if (sclk_fall) begin
                    rdy_n_nxt  = 1'b1;                                    // [RULE11]
                    rdy_st_nxt = RDY_HIGH;
                end
            end
            RDY_PULSE: begin
                if (pw_r == 8'h00) begin
                    rdy_n_nxt  = 1'b0;
                    rdy_st_nxt = RDY_LOW;
                end else begin
                    pw_nxt = pw_r - 8'h01;
                end
            end
            default: begin
                rdy_st_nxt = RDY_HIGH;
            end
        endcase
    end

    // reset pin returns everything to default and restarts conversion [RULE20]
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            res_buf_r <= 16'h0000;
            shift_r   <= 16'h0000;
            out_cnt_r <= 5'h00;
            in_sr_r   <= 8'h00;
            bit_cnt_r <= 3'h0;
            cont_r    <= `RESET_CONT_READ;
            dout_r    <= 1'b1;
            oe_r      <= 1'b0;
            drained_r <= 1'b1;
            idle_r    <= 7'h00;
            pend_r    <= 1'b0;
            rdy_st_r  <= RDY_HIGH;
            pw_r      <= 8'h00;
            rdy_n_r   <= 1'b1;
            cready_r  <= 1'b0;
            restart_r <= 1'b1;
        end else begin
            res_buf_r <= res_buf_nxt;
            shift_r   <= shift_nxt;
            out_cnt_r <= out_cnt_nxt;
            in_sr_r   <= in_sr_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            cont_r    <= cont_nxt;
            dout_r    <= dout_nxt;
            oe_r      <= oe_nxt;
            drained_r <= drained_nxt;
            idle_r    <= idle_nxt;
            pend_r    <= pend_nxt;
            rdy_st_r  <= rdy_st_nxt;
            pw_r      <= pw_nxt;
            rdy_n_r   <= rdy_n_nxt;
            cready_r  <= f_in_ready;
            restart_r <= 1'b0;
        end
    end

    always_comb begin
        conv_ready              = cready_r;
        result_ready_n          = rdy_n_r;
        shared_out_ready_pin_o  = dout_r;
        shared_out_ready_pin_oe = oe_r;
        continuous_read_mode    = cont_r;
        conv_restart            = restart_r;
    end
endmodule // adc_spi_slave_ready_iface

// *** logic/result_fifo.sv ***
/*
 * small flop fifo holding conversion results between converter and shifter.
 * assumes one clock and an asynchronous active-high reset.
 */
`timescale 1ns/1ps

module result_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
        $error("result_fifo depth must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0]      wr_r;
    logic [AW:0]      wr_nxt;
    logic [AW:0]      rd_r;
    logic [AW:0]      rd_nxt;
    logic             push;
    logic             pop;

    always_comb begin
        in_ready  = (wr_r - rd_r) != (AW+1)'(DEPTH);
        out_valid = wr_r != rd_r;
        out_data  = mem_r[rd_r[AW-1:0]];
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        wr_nxt    = push ? wr_r + 1'b1 : wr_r;
        rd_nxt    = pop ? rd_r + 1'b1 : rd_r;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_r <= '0;
            rd_r <= '0;
        end else begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_r[wr_r[AW-1:0]] <= in_data;
        end
    end
endmodule // result_fifo

// *** logic/spi_ready_map.svh ***
/*
 * named offsets, widths and timing counts of the serial ready interface.
 * assumes inclusion by the package, the top module and the top bench only.
 */
`ifndef SPI_READY_MAP_SVH
`define SPI_READY_MAP_SVH

`define CLK_PERIOD_PS        5000
`define PULSE_HIGH_TIME_PS   20000
`define PULSE_HIGH_CYCLES    ((`PULSE_HIGH_TIME_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define RESULT_BITS          16
`define BYTE_BITS            8
`define IDLE_TIMEOUT_CONV    64
`define CMD_NOP              8'hFF
`define CMD_READ_ONCE        8'h12
`define CMD_CONT_READ        8'h14
`define CMD_STOP_CONT        8'h16
`define CMD_OP_MASK          8'hFE
`define RESET_CONT_READ      1'b1

`endif

// *** logic/spi_ready_pkg.sv ***
/*
 * types shared by the serial ready interface.
 * assumes the map header sits beside it.
 */
`include "spi_ready_map.svh"

package spi_ready_pkg;
    typedef struct packed {
        logic [15:0] data;
    } result_word_t;

    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic din;
    } serial_in_t;

    typedef enum logic [1:0] {
        RDY_LOW,
        RDY_HIGH,
        RDY_PULSE
    } ready_state_t;
endpackage
